// ---- common/tps_pkg.sv ----
// Constants, field layouts and carrier types for the two-port block memory.
// Assumes a single 100 MHz system clock and an Avalon-MM register master.
package tps_pkg;

   // ------------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------------
   localparam int unsigned DATA_W = 18;
   localparam int unsigned HALF_W = 9;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned SCAN_BITS = 4608;
   localparam int unsigned SCAN_CNT_W = 13;
   localparam int unsigned WORD_BIT_W = 5;

   // ------------------------------------------------------------------
   // Width select codes
   // ------------------------------------------------------------------
   localparam logic [1:0] WIDTH_X9 = 2'h1;
   localparam logic [1:0] WIDTH_X18 = 2'h2;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int unsigned AVS_ADDR_W = 4;
   localparam int unsigned AVS_DATA_W = 32;
   localparam logic [3:0] CFG_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;

   // Configuration register, bits 6..0 from the top field down.
   typedef struct packed {
      logic [1:0] read_width_sel;
      logic [1:0] write_width_sel;
      logic rd_act_hi;
      logic wr_act_hi;
      logic output_register_sel;
   } tps_cfg_t;

   localparam int unsigned CFG_W = $bits(tps_cfg_t);
   localparam tps_cfg_t CFG_RST = '{
      read_width_sel: WIDTH_X9,
      write_width_sel: WIDTH_X9,
      rd_act_hi: 1'b0,
      wr_act_hi: 1'b0,
      output_register_sel: 1'b0
   };

   // Status register, bits 14..0 from the top field down.
   typedef struct packed {
      logic [SCAN_CNT_W-1:0] scan_bits;
      logic scan_busy;
      logic scan_done;
   } tps_stat_t;

   // Avalon-MM request group.
   typedef struct packed {
      logic read;
      logic write;
      logic [AVS_ADDR_W-1:0] address;
      logic [AVS_DATA_W-1:0] writedata;
      logic [3:0] byteenable;
   } tps_avs_req_t;

   typedef enum logic [1:0] {
      SCAN_IDLE,
      SCAN_LOAD,
      SCAN_DONE
   } tps_scan_st_t;

endpackage

// ---- src/tps_sram.sv ----
// Two-port block memory with separate write and read ports, a boundary-scan
// preload path and an Avalon-MM configuration slave.
// Assumes the fabric drives both ports from logic on clk_i.
`timescale 1ns/100ps
module tps_sram #(
   parameter bit WR_FALL_EDGE = 1'b0,
   parameter bit RD_FALL_EDGE = 1'b0,
   parameter int unsigned SCAN_LEN = tps_pkg::SCAN_BITS
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire tps_pkg::tps_avs_req_t avs_req_i,
   output logic [tps_pkg::AVS_DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic mem_reset_n_i,
   input wire logic write_en_i,
   input wire logic [tps_pkg::ADDR_W-1:0] write_addr_i,
   input wire logic [tps_pkg::DATA_W-1:0] write_data_i,
   input wire logic read_en_i,
   input wire logic [tps_pkg::ADDR_W-1:0] read_addr_i,
   output logic [tps_pkg::DATA_W-1:0] read_data_o,
   input wire logic scan_sel_i,
   input wire logic scan_clk_i,
   input wire logic scan_bit_i,
   output logic scan_done_o
);
   import tps_pkg::*;

   if (SCAN_LEN != (2 ** ADDR_W) * HALF_W || SCAN_LEN >= 2 ** SCAN_CNT_W) begin
      $error("SCAN_LEN must equal the array size in bits.");
   end

   // ------------------------------------------------------------------
   // Port clocks
   // ------------------------------------------------------------------
   wire wr_clk = clk_i ^ WR_FALL_EDGE;
   wire rd_clk = clk_i ^ RD_FALL_EDGE;
   wire mem_run = mem_reset_n_i & ~reset_i;

   // ------------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------------
   tps_cfg_t cfg;
   tps_stat_t stat;
   tps_scan_st_t scan_st;
   logic [SCAN_CNT_W-1:0] bit_cnt;

   wire avs_req = avs_req_i.read | avs_req_i.write;
   wire avs_take = avs_req & ~avs_waitrequest_o;
   wire hit_cfg = avs_req_i.address == CFG_OFS;
   wire hit_stat = avs_req_i.address == STAT_OFS;
   wire cfg_we = avs_take & avs_req_i.write & hit_cfg
      & avs_req_i.byteenable[0] & ~mem_reset_n_i;
   wire [AVS_DATA_W-1:0] next_rdata = hit_cfg ? AVS_DATA_W'(cfg)
      : hit_stat ? AVS_DATA_W'(stat) : '0;

   assign stat.scan_bits = bit_cnt;
   assign stat.scan_busy = scan_st == SCAN_LOAD;
   assign stat.scan_done = scan_done_o;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= '0;
         cfg <= CFG_RST;
      end else begin
         avs_waitrequest_o <= ~(avs_req & avs_waitrequest_o);
         if (avs_req & avs_waitrequest_o) begin
            avs_readdata_o <= next_rdata;
         end
         if (cfg_we) begin
            cfg <= tps_cfg_t'(avs_req_i.writedata[CFG_W-1:0]);
         end
      end
   end

   // ------------------------------------------------------------------
   // Scan pin synchronisers
   // ------------------------------------------------------------------
   logic [2:0] pin_s1, pin_s2, pin_s3, pin_f;
   logic sclk_prev;
   wire [2:0] pin_raw = {scan_bit_i, scan_clk_i, scan_sel_i};
   wire [2:0] pin_agree = pin_s2 ~^ pin_s3;
   wire [2:0] next_pin_f = (pin_agree & pin_s3) | (~pin_agree & pin_f);

   always_ff @(posedge wr_clk) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (reset_i) begin
         pin_f <= '0;
         sclk_prev <= 1'b0;
      end else begin
         pin_f <= next_pin_f;
         sclk_prev <= pin_f[1];
      end
   end

   // ------------------------------------------------------------------
   // Scan preload engine
   // ------------------------------------------------------------------
   logic [DATA_W-2:0] scan_sh;
   logic [WORD_BIT_W-1:0] word_bit;
   logic [ADDR_W-2:0] scan_addr;

   wire scan_sel = pin_f[0];
   wire sclk_rise = pin_f[1] & ~sclk_prev;
   wire scan_shift = mem_run & scan_sel & sclk_rise & (scan_st == SCAN_LOAD);
   wire word_last = word_bit == WORD_BIT_W'(DATA_W - 1);
   wire scan_wr = scan_shift & word_last;
   wire [DATA_W-1:0] scan_word = {scan_sh, pin_f[2]};
   wire scan_end = bit_cnt == SCAN_CNT_W'(SCAN_LEN - 1);

   always_ff @(posedge wr_clk) begin
      if (reset_i) begin
         scan_st <= SCAN_IDLE;
         scan_sh <= '0;
         word_bit <= '0;
         scan_addr <= '0;
         bit_cnt <= '0;
         scan_done_o <= 1'b0;
      end else begin
         case (scan_st)
            SCAN_IDLE: begin
               if (scan_sel) begin
                  scan_st <= SCAN_LOAD;
                  word_bit <= '0;
                  scan_addr <= '0;
                  bit_cnt <= '0;
                  scan_done_o <= 1'b0;
               end
            end
            SCAN_LOAD: begin
               if (!scan_sel) begin
                  scan_st <= SCAN_IDLE;
               end else if (scan_shift) begin
                  scan_sh <= scan_word[DATA_W-2:0];
                  word_bit <= word_last ? '0 : word_bit + 1'b1;
                  scan_addr <= scan_addr + (ADDR_W-1)'(word_last);
                  bit_cnt <= bit_cnt + 1'b1;
                  if (scan_end) begin
                     scan_st <= SCAN_DONE;
                     scan_done_o <= 1'b1;
                  end
               end
            end
            SCAN_DONE: begin
               if (!scan_sel) begin
                  scan_st <= SCAN_IDLE;
               end
            end
            default: begin
               scan_st <= SCAN_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Write port
   // ------------------------------------------------------------------
   logic [HALF_W-1:0] mem [0:2**ADDR_W-1];

   wire wr_x9 = cfg.write_width_sel == WIDTH_X9;
   wire wr_x18 = cfg.write_width_sel == WIDTH_X18;
   wire wr_en_act = write_en_i ~^ cfg.wr_act_hi;
   wire scan_busy = scan_st == SCAN_LOAD;
   wire wr_fire = mem_run & ~scan_busy & wr_en_act & (wr_x9 | wr_x18);
   wire [ADDR_W-1:0] wr_lo = wr_x9 ? write_addr_i
      : {write_addr_i[ADDR_W-2:0], 1'b0};
   wire [ADDR_W-1:0] wr_hi = {wr_lo[ADDR_W-1:1], 1'b1};
   wire [HALF_W-1:0] wr_lo_data = write_data_i[HALF_W-1:0];

   // Preload takes the array over; fabric writes are dropped while it loads.
   always_ff @(posedge wr_clk) begin
      if (scan_wr) begin
         mem[{scan_addr, 1'b0}] <= scan_word[HALF_W-1:0];
         mem[{scan_addr, 1'b1}] <= scan_word[DATA_W-1:HALF_W];
      end else if (wr_fire) begin
         mem[wr_lo] <= wr_lo_data;
         if (wr_x18) begin
            mem[wr_hi] <= write_data_i[DATA_W-1:HALF_W];
         end
      end
   end

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] rd_stage;
   logic rd_stage_vld;

   wire rd_x9 = cfg.read_width_sel == WIDTH_X9;
   wire rd_x18 = cfg.read_width_sel == WIDTH_X18;
   wire rd_en_act = read_en_i ~^ cfg.rd_act_hi;
   wire rd_fire = mem_run & rd_en_act & (rd_x9 | rd_x18);
   wire [ADDR_W-1:0] rd_lo = {read_addr_i[ADDR_W-2:0], 1'b0};
   wire [ADDR_W-1:0] rd_hi = {read_addr_i[ADDR_W-2:0], 1'b1};
   wire [DATA_W-1:0] rd_word = rd_x9 ? DATA_W'(mem[read_addr_i])
      : {mem[rd_hi], mem[rd_lo]};
   wire pipe = cfg.output_register_sel;
   wire rd_load = pipe ? rd_stage_vld : rd_fire;
   wire [DATA_W-1:0] next_read_data = pipe ? rd_stage : rd_word;

   always_ff @(posedge rd_clk) begin
      if (!mem_run) begin
         read_data_o <= '0;
         rd_stage <= '0;
         rd_stage_vld <= 1'b0;
      end else begin
         rd_stage_vld <= rd_fire & pipe;
         if (rd_fire) begin
            rd_stage <= rd_word;
         end
         if (rd_load) begin
            read_data_o <= next_read_data;
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   rd_nopipe_a: assert property (@(posedge rd_clk) disable iff (reset_i)
      rd_fire && !pipe |=> read_data_o == $past(rd_word))
      else $error("Unregistered read word not presented after one edge.");

   rd_narrow_a: assert property (@(posedge rd_clk) disable iff (reset_i)
      rd_fire && !pipe && rd_x9 |=> read_data_o[DATA_W-1:HALF_W] == '0)
      else $error("Narrow read left upper data bits set.");

   rd_pipe_a: assert property (@(posedge rd_clk) disable iff (reset_i)
      rd_fire && pipe ##1 mem_run |=> read_data_o == $past(rd_word, 2))
      else $error("Registered read word not presented after two edges.");

   rd_hold_a: assert property (@(posedge rd_clk) disable iff (reset_i)
      mem_run && !rd_fire && !rd_stage_vld |=> $stable(read_data_o))
      else $error("Read data changed without an enabled read.");

   wr_store_a: assert property (@(posedge wr_clk) disable iff (reset_i)
      wr_fire && wr_x18 && !scan_wr
      |=> {mem[$past(wr_hi)], mem[$past(wr_lo)]} == $past(write_data_i))
      else $error("Wide write did not store the word.");

   en_level_a: assert property (@(posedge wr_clk) disable iff (reset_i)
      mem_run && !scan_busy && wr_x9 && !scan_wr
      && write_en_i == cfg.wr_act_hi
      |=> mem[$past(write_addr_i)] == $past(wr_lo_data))
      else $error("Narrow write at the configured enable level was lost.");

   rd_rsvd_a: assert property (@(posedge rd_clk) disable iff (reset_i)
      mem_run && !rd_x9 && !rd_x18 && !rd_stage_vld
      |=> $stable(read_data_o))
      else $error("Reserved read width produced data.");

   mem_reset_a: assert property (@(posedge rd_clk) disable iff (reset_i)
      !mem_run |=> read_data_o == '0 && !rd_stage_vld)
      else $error("Memory reset did not clear the output.");

   scan_len_a: assert property (@(posedge wr_clk) disable iff (reset_i)
      $rose(scan_done_o) |-> bit_cnt == SCAN_CNT_W'(SCAN_LEN)
      && $past(scan_st) == SCAN_LOAD)
      else $error("Preload finished at the wrong bit count.");

   scan_top_a: assert property (@(posedge wr_clk) disable iff (reset_i)
      scan_wr && scan_end |-> scan_addr == '1)
      else $error("Preload did not end on the top word.");

   rescan_a: assert property (@(posedge wr_clk) disable iff (reset_i)
      scan_st == SCAN_IDLE && scan_sel |=> !scan_done_o && bit_cnt == '0)
      else $error("Preload select did not restart the load.");

   cfg_static_a: assert property (@(posedge clk_i) disable iff (reset_i)
      mem_run |=> $stable(cfg))
      else $error("Configuration changed while the memory was running.");

   bus_answer_a: assert property (@(posedge clk_i) disable iff (reset_i)
      avs_req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("Bus request not answered in one cycle.");

   pipe_read_c: cover property (@(posedge rd_clk) disable iff (reset_i)
      rd_fire && pipe ##1 rd_stage_vld ##1 mem_run);
   nopipe_read_c: cover property (@(posedge rd_clk) disable iff (reset_i)
      rd_fire && !pipe && rd_x18);
   scan_done_c: cover property (@(posedge wr_clk) disable iff (reset_i)
      $rose(scan_done_o));
   cfg_write_c: cover property (@(posedge clk_i) disable iff (reset_i)
      cfg_we);
   rsvd_read_c: cover property (@(posedge rd_clk) disable iff (reset_i)
      mem_run && !rd_x9 && !rd_x18 && rd_en_act);

endmodule

// ---- dv/tps_fabric.sv ----
// Fabric-side model that drives the write, read and preload ports.
// Assumes its tasks are called from one process clocked on clk_i.
`timescale 1ns/100ps
module tps_fabric (
   input wire logic clk_i,
   output logic write_en_o,
   output logic [tps_pkg::ADDR_W-1:0] write_addr_o,
   output logic [tps_pkg::DATA_W-1:0] write_data_o,
   output logic read_en_o,
   output logic [tps_pkg::ADDR_W-1:0] read_addr_o,
   output logic scan_sel_o,
   output logic scan_clk_o,
   output logic scan_bit_o
);
   import tps_pkg::*;
   logic wr_hi = 1'b0;
   logic rd_hi = 1'b0;
   logic x18 = 1'b0;
   initial begin
      write_en_o = 1'b1;
      write_addr_o = 9'h0;
      write_data_o = 18'h0;
      read_en_o = 1'b1;
      read_addr_o = 9'h0;
      scan_sel_o = 1'b0;
      scan_clk_o = 1'b0;
      scan_bit_o = 1'b0;
   end
   // ---------------------------------------------------------------
   // Port tasks
   // ---------------------------------------------------------------
   task automatic set_mode(input logic w, input logic r, input logic x);
      @(posedge clk_i);
      wr_hi = w;
      rd_hi = r;
      x18 = x;
      write_en_o <= ~w;
      read_en_o <= ~r;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      write_en_o <= wr_hi;
      write_addr_o <= x18 ? {1'b0, a[ADDR_W-2:0]} : a;
      write_data_o <= x18 ? d : {9'h0, d[HALF_W-1:0]};
      @(posedge clk_i);
      write_en_o <= ~wr_hi;
      write_data_o <= x18 ? ~d : {9'h0, ~d[HALF_W-1:0]};
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input bit en);
      @(posedge clk_i);
      read_en_o <= en ? rd_hi : ~rd_hi;
      read_addr_o <= x18 ? {1'b0, a[ADDR_W-2:0]} : a;
      @(posedge clk_i);
      read_en_o <= ~rd_hi;
      read_addr_o <= x18 ? {1'b0, ~a[ADDR_W-2:0]} : ~a;
   endtask
   task automatic preload();
      logic [7:0] k;
      logic [DATA_W-1:0] w;
      @(posedge clk_i);
      scan_sel_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      for (int i = 0; i < SCAN_BITS; i++) begin
         k = 8'(i / DATA_W);
         w = {k, 1'b0, ~k, 1'b1};
         scan_bit_o <= w[DATA_W - 1 - i % DATA_W];
         scan_clk_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         scan_clk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
      end
      scan_clk_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      scan_sel_o <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// ---- dv/tps_sram_bench.sv ----
// Self-checking bench for the two-port block memory.
// Assumes one 100 MHz clock; the fabric model also drives the preload port.
`timescale 1ns/100ps
module tps_sram_bench;
   import tps_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic mem_reset_n = 1'b0;
   tps_avs_req_t avs_req = '0;
   logic [AVS_DATA_W-1:0] rdata;
   logic wait_req;
   logic wen;
   logic ren;
   logic [ADDR_W-1:0] write_addr;
   logic [ADDR_W-1:0] raddr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rd_q;
   logic ssel;
   logic sclk;
   logic sbit;
   logic sdone;
   int failures = 0;
   int n_tests = 0;
   tps_fabric tps_fabric_i (.clk_i(clk_i), .write_en_o(wen),
      .write_addr_o(write_addr), .write_data_o(wdata), .read_en_o(ren),
      .read_addr_o(raddr), .scan_sel_o(ssel), .scan_clk_o(sclk),
      .scan_bit_o(sbit));
   tps_sram tps_sram_i (.clk_i(clk_i), .reset_i(reset_i),
      .avs_req_i(avs_req), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_req), .mem_reset_n_i(mem_reset_n),
      .write_en_i(wen), .write_addr_i(write_addr), .write_data_i(wdata),
      .read_en_i(ren), .read_addr_i(raddr), .read_data_o(rd_q),
      .scan_sel_i(ssel), .scan_clk_i(sclk), .scan_bit_i(sbit),
      .scan_done_o(sdone));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic av(input bit wr, input logic [3:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      q = 32'h0;
      @(posedge clk_i);
      avs_req.read <= ~wr;
      avs_req.write <= wr;
      avs_req.address <= a;
      avs_req.writedata <= d;
      avs_req.byteenable <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wait_req !== 1'b0 && n < 20);
      if (wait_req !== 1'b0) begin
         failures++;
         $display("ERROR %0t bus wait ran out", $time);
         results();
      end
      q = rdata;
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
   endtask
   task automatic set_cfg(input tps_cfg_t c);
      logic [31:0] q;
      @(posedge clk_i);
      mem_reset_n <= 1'b0;
      av(1'b1, CFG_OFS, {25'h0, c}, q);
      tps_fabric_i.set_mode(c.wr_act_hi, c.rd_act_hi, c.read_width_sel[1]);
      @(posedge clk_i);
      mem_reset_n <= 1'b1;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_regs;
      logic [31:0] q;
      av(1'b0, CFG_OFS, 32'h0, q);
      chk(q, {25'h0, CFG_RST});
      av(1'b0, STAT_OFS, 32'h0, q);
      chk(q, 32'h0);
      av(1'b0, 4'h8, 32'h0, q);
      chk(q, 32'h0);
      @(posedge clk_i);
      mem_reset_n <= 1'b1;
      av(1'b1, CFG_OFS, 32'h0000_0001, q);
      av(1'b0, CFG_OFS, 32'h0, q);
      chk(q, {25'h0, CFG_RST});
      $display("test_regs done");
   endtask
   task automatic test_nonpipe;
      tps_fabric_i.wr(9'h005, 18'h000a5);
      tps_fabric_i.wr(9'h006, 18'h0015a);
      tps_fabric_i.rd(9'h005, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0000_00a5);
      tps_fabric_i.rd(9'h006, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0000_015a);
      tps_fabric_i.rd(9'h005, 1'b0);
      #1 chk({14'h0, rd_q}, 32'h0000_015a);
      $display("test_nonpipe done");
   endtask
   task automatic test_mem_reset;
      @(posedge clk_i);
      mem_reset_n <= 1'b0;
      tps_fabric_i.wr(9'h005, 18'h001ff);
      #1 chk({14'h0, rd_q}, 32'h0);
      @(posedge clk_i);
      mem_reset_n <= 1'b1;
      tps_fabric_i.rd(9'h005, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0000_00a5);
      $display("test_mem_reset done");
   endtask
   task automatic test_pipe;
      set_cfg('{WIDTH_X9, WIDTH_X9, 1'b0, 1'b0, 1'b1});
      tps_fabric_i.rd(9'h006, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0);
      @(posedge clk_i);
      #1 chk({14'h0, rd_q}, 32'h0000_015a);
      $display("test_pipe done");
   endtask
   task automatic test_wide;
      set_cfg('{WIDTH_X18, WIDTH_X18, 1'b1, 1'b1, 1'b0});
      tps_fabric_i.wr(9'h003, 18'h2bcd5);
      tps_fabric_i.rd(9'h003, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0002_bcd5);
      set_cfg('{WIDTH_X18, 2'h0, 1'b1, 1'b1, 1'b0});
      tps_fabric_i.wr(9'h003, 18'h01111);
      tps_fabric_i.rd(9'h003, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0002_bcd5);
      set_cfg('{2'h3, WIDTH_X18, 1'b1, 1'b1, 1'b0});
      tps_fabric_i.wr(9'h003, 18'h01111);
      tps_fabric_i.rd(9'h003, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0);
      $display("test_wide done");
   endtask
   task automatic test_scan;
      logic [31:0] q;
      set_cfg('{WIDTH_X18, WIDTH_X18, 1'b1, 1'b1, 1'b0});
      tps_fabric_i.rd(9'h003, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0000_1111);
      tps_fabric_i.preload();
      chk({31'h0, sdone}, 32'h1);
      av(1'b0, STAT_OFS, 32'h0, q);
      chk(q, {17'h0, SCAN_CNT_W'(SCAN_BITS), 2'b01});
      tps_fabric_i.rd(9'h0ff, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0003_fc01);
      tps_fabric_i.rd(9'h000, 1'b1);
      #1 chk({14'h0, rd_q}, 32'h0000_01ff);
      $display("test_scan done");
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      test_regs();
      test_nonpipe();
      test_mem_reset();
      test_pipe();
      test_wide();
      test_scan();
      results();
   end
endmodule
